// file: include/i2cm_pkg.sv
// I2C master engine: register map, field positions, timing constants and types.
// Assumes a 32-bit APB slave, byte addresses, one aligned word per register.
package i2cm_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_CFG  = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_BUF  = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BYTE_W = 8;

    // ==========================================================
    // Fields and reset values
    localparam int unsigned   CFG_EN   = 0;
    localparam int unsigned   BAUD_W   = 8;
    localparam logic [7:0]    BAUD_RST = 8'h13;
    localparam int unsigned   FLAG_W   = 3;
    localparam int unsigned   FL_SPIF  = 0;
    localparam int unsigned   FL_BCL   = 1;
    localparam int unsigned   FL_WR_COLL = 2;
    localparam int unsigned   CTRL_W   = 6;
    localparam int unsigned   REQ_W    = 5;
    localparam logic [2:0]    FLAG_RST = 3'h0;

    // ==========================================================
    // Bit counts per sequence
    localparam logic [3:0] NBITS_TX  = 4'h9;
    localparam logic [3:0] NBITS_RX  = 4'h8;
    localparam logic [3:0] NBITS_ACK = 4'h1;
    localparam logic [3:0] CNT_ONE   = 4'h1;

    // ==========================================================
    // Types
    typedef struct packed {
        logic ack_data;
        logic ack_en;
        logic rcv_en;
        logic stop;
        logic rstart;
        logic start;
    } i2cm_ctrl_t;

    typedef struct packed {
        logic       busy;
        logic       stop_seen;
        logic       start_seen;
        logic       ack_rcvd;
        logic       buffer_full_flag;
        logic [2:0] flags;
    } i2cm_stat_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_STA_A = 4'b0001,
        ST_STA_B = 4'b0010,
        ST_RSA_A = 4'b0011,
        ST_RSA_B = 4'b0100,
        ST_STP_A = 4'b0101,
        ST_STP_B = 4'b0110,
        ST_STP_C = 4'b0111,
        ST_BIT_L = 4'b1000,
        ST_BIT_H = 4'b1001
    } i2cm_state_t;

    typedef enum logic [1:0] {
        MD_TX  = 2'b00,
        MD_RX  = 2'b01,
        MD_ACK = 2'b10
    } i2cm_mode_t;

endpackage : i2cm_pkg

// file: hdl/i2cm_brg.sv
// Baud rate generator for the I2C master: one tick per SCL half period.
// Assumes the caller decides when SCL is released and not yet seen high.
`timescale 1ns/1ps
module i2cm_baud_gen
    import i2cm_pkg::*;
#(
    parameter int unsigned W = BAUD_W
) (
    input  wire logic         pclk,     // System clock
    input  wire logic         presetn,  // Async reset, active low
    input  wire logic         load,     // Reload from reload value
    input  wire logic         hold,     // Freeze count
    input  wire logic [W-1:0] reload,   // Reload value
    output logic              tick      // Rollover, half period end
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    wire          at_zero = (count_r == '0);

    assign tick = !load && !hold && at_zero;

    // ==========================================================
    // Counter
    always_comb begin
        if (load) begin
            count_nxt = reload;
        end else if (hold) begin
            count_nxt = count_r;
        end else if (at_zero) begin
            count_nxt = reload;
        end else begin
            count_nxt = count_r - W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) count_r <= '0;
        else          count_r <= count_nxt;
    end

    hold_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        !load && hold |=> $stable(count_r)) else $error("count moved under hold");
    reload_val_a: assert property (@(posedge pclk) disable iff (!presetn)
        load |=> count_r == $past(reload)) else $error("reload missed");

endmodule : i2cm_baud_gen

// file: hdl/i2cm_master.sv
// I2C master engine with APB registers, collision handling and interrupt.
// Assumes open-drain pads outside that resolve the enables; pins are async.
`timescale 1ns/1ps

// Contract
// - Master drives all SCL pulses, starts, stops
// - Transfer ends by stop or repeated start
// - Transmit: address byte, eight bits, sample ack
// - Receive: clock in eight bits, set full; ack_en sends the ack
// - Generator holds while released SCL reads low
// - Generator reloads when SCL seen high
// - Buffer write while busy: discarded, flag set
// - Transmit collision: stop, clear full, release
// - Sequence collision: abort, release, clear requests
// - After collision, stop on bus sets flag
// - New write restarts at first data bit
// - Start collision: line low early or SCL
// - Start collision: abort, flag, go idle
module i2cm_master
    import i2cm_pkg::*;
(
    input  wire logic              pclk,     // System clock, 125 MHz
    input  wire logic              presetn,  // Async reset, active low
    input  wire logic [ADDR_W-1:0] paddr,    // APB address
    input  wire logic              psel,     // APB select
    input  wire logic              penable,  // APB enable
    input  wire logic              pwrite,   // APB write
    input  wire logic [DATA_W-1:0] pwdata,   // APB write data
    output logic      [DATA_W-1:0] prdata,   // APB read data
    output logic                   pready,   // APB ready
    output logic                   pslverr,  // APB error, unmapped
    output logic                   irq,      // Interrupt level
    input  wire logic              scl_i,    // SCL line level
    output logic                   scl_o,    // SCL drive value
    output logic                   scl_oe,   // SCL pulled low
    input  wire logic              sda_i,    // SDA line level
    output logic                   sda_o,    // SDA drive value
    output logic                   sda_oe    // SDA pulled low
);

    // ==========================================================
    // Declarations
    i2cm_state_t         state_r, state_nxt;
    i2cm_mode_t          mode_r, mode_nxt;
    i2cm_ctrl_t          ctrl_r, ctrl_nxt;
    logic [REQ_W-1:0]    ctrl_clr;
    logic [BAUD_W-1:0]   baud_r;
    logic                en_r;
    logic [FLAG_W-1:0]   flag_r, flag_nxt, flag_set, mask_r;
    logic [BYTE_W-1:0]   shift_r, shift_nxt;
    logic [3:0]          cnt_r, cnt_nxt;
    logic                full_r, full_nxt, ack_r, ack_nxt;
    logic                scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
    logic                sdet_r, pdet_r, watch_r, coll;
    logic                scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic [DATA_W-1:0]   prdata_r;
    logic                pready_r, pslverr_r, irq_r;
    logic                tick;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction : hit

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
        end
    end

    wire scl_rise  = scl_s2 && !scl_s3;
    wire start_bus = !sda_s2 && sda_s3 && scl_s2 && scl_s3;
    wire stop_bus  = sda_s2 && !sda_s3 && scl_s2 && scl_s3;

    // ==========================================================
    // APB decode
    wire setup    = psel && !penable;
    wire acc      = psel && penable && pready_r;
    wire wr       = acc && pwrite;
    wire rd       = acc && !pwrite;
    wire sel_cfg  = hit(paddr, OFS_CFG);
    wire sel_baud = hit(paddr, OFS_BAUD);
    wire sel_ctrl = hit(paddr, OFS_CTRL);
    wire sel_buf  = hit(paddr, OFS_BUF);
    wire sel_stat = hit(paddr, OFS_STAT);
    wire sel_mask = hit(paddr, OFS_MASK);
    wire mapped   = sel_cfg | sel_baud | sel_ctrl | sel_buf | sel_stat | sel_mask;
    wire idle     = (state_r == ST_IDLE);
    wire busy     = !idle || (|ctrl_r[REQ_W-1:0]);
    wire buf_wr   = wr && sel_buf;
    wire buf_ok   = buf_wr && !busy && en_r;
    wire wr_coll  = buf_wr && !(!busy && en_r);
    wire ctrl_wr  = wr && sel_ctrl;

    i2cm_stat_t stat;
    assign stat = '{busy: !idle, stop_seen: pdet_r, start_seen: sdet_r,
                    ack_rcvd: ack_r, buffer_full_flag: full_r, flags: flag_r};

    wire [DATA_W-1:0] rd_mux =
        sel_cfg  ? DATA_W'(en_r)    :
        sel_baud ? DATA_W'(baud_r)  :
        sel_ctrl ? DATA_W'(ctrl_r)  :
        sel_buf  ? DATA_W'(shift_r) :
        sel_stat ? DATA_W'(stat)    :
        sel_mask ? DATA_W'(mask_r)  : '0;

    // ==========================================================
    // Sequencer
    wire [3:0] nbits   = (mode_r == MD_TX) ? NBITS_TX :
                         (mode_r == MD_RX) ? NBITS_RX : NBITS_ACK;
    wire [3:0] cnt_inc = cnt_r + CNT_ONE;
    // Drove a one (released) in a slot we own: a low read means we lost
    wire own_one = !sda_oe_r && (mode_r == MD_ACK || (mode_r == MD_TX && cnt_r < NBITS_RX));

    always_comb begin
        state_nxt  = state_r;
        mode_nxt   = mode_r;
        scl_oe_nxt = scl_oe_r;
        sda_oe_nxt = sda_oe_r;
        shift_nxt  = shift_r;
        cnt_nxt    = cnt_r;
        full_nxt   = full_r;
        ack_nxt    = ack_r;
        ctrl_clr   = '0;
        flag_set   = '0;
        coll       = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (rd && sel_buf) full_nxt = 1'b0;
                if (!en_r) begin
                    scl_oe_nxt = 1'b0;
                    sda_oe_nxt = 1'b0;
                end else if (ctrl_r.start) begin
                    state_nxt  = ST_STA_A;
                    scl_oe_nxt = 1'b0;
                    sda_oe_nxt = 1'b0;
                end else if (ctrl_r.rstart) begin
                    state_nxt  = ST_RSA_A;
                    sda_oe_nxt = 1'b0;
                end else if (ctrl_r.stop) begin
                    state_nxt  = ST_STP_A;
                    scl_oe_nxt = 1'b1;
                    sda_oe_nxt = 1'b1;
                end else if (ctrl_r.rcv_en || ctrl_r.ack_en) begin
                    state_nxt  = ST_BIT_L;
                    mode_nxt   = ctrl_r.rcv_en ? MD_RX : MD_ACK;
                    cnt_nxt    = '0;
                    scl_oe_nxt = 1'b1;
                    sda_oe_nxt = !ctrl_r.rcv_en && !ctrl_r.ack_data;
                end else if (buf_ok) begin
                    state_nxt  = ST_BIT_L;
                    mode_nxt   = MD_TX;
                    shift_nxt  = pwdata[BYTE_W-1:0];
                    cnt_nxt    = '0;
                    full_nxt   = 1'b1;
                    scl_oe_nxt = 1'b1;
                    sda_oe_nxt = !pwdata[BYTE_W-1];
                end
            end
            ST_STA_A: begin
                if (!scl_s2 || !sda_s2) begin
                    coll = 1'b1;
                end else if (tick) begin
                    state_nxt  = ST_STA_B;
                    sda_oe_nxt = 1'b1;
                end
            end
            ST_STA_B: begin
                if (tick) begin
                    state_nxt  = ST_IDLE;
                    scl_oe_nxt = 1'b1;
                    ctrl_clr   = REQ_W'(3);
                    flag_set[FL_SPIF] = 1'b1;
                end
            end
            ST_RSA_A: begin
                if (tick) begin
                    state_nxt  = ST_RSA_B;
                    scl_oe_nxt = 1'b0;
                end
            end
            ST_RSA_B: begin
                if (scl_s2 && !sda_s2) begin
                    coll = 1'b1;
                end else if (tick) begin
                    state_nxt  = ST_STA_B;
                    sda_oe_nxt = 1'b1;
                end
            end
            ST_STP_A: begin
                if (tick) begin
                    state_nxt  = ST_STP_B;
                    scl_oe_nxt = 1'b0;
                end
            end
            ST_STP_B: begin
                if (tick) begin
                    state_nxt  = ST_STP_C;
                    sda_oe_nxt = 1'b0;
                end
            end
            ST_STP_C: begin
                if (tick && !sda_s2) begin
                    coll = 1'b1;
                end else if (tick) begin
                    state_nxt = ST_IDLE;
                    ctrl_clr  = REQ_W'(4);
                    flag_set[FL_SPIF] = 1'b1;
                end
            end
            ST_BIT_L: begin
                if (tick) begin
                    state_nxt  = ST_BIT_H;
                    scl_oe_nxt = 1'b0;
                end
            end
            ST_BIT_H: begin
                // Sample at the end of the high half, when SDA has settled
                if (tick && own_one && !sda_s2) begin
                    coll = 1'b1;
                end else if (tick) begin
                    cnt_nxt    = cnt_inc;
                    scl_oe_nxt = 1'b1;
                    if (cnt_r < NBITS_RX && mode_r != MD_ACK) begin
                        shift_nxt = {shift_r[BYTE_W-2:0], sda_s2};
                    end
                    if (cnt_inc == nbits) begin
                        state_nxt  = ST_IDLE;
                        sda_oe_nxt = 1'b0;
                        flag_set[FL_SPIF] = 1'b1;
                        if (mode_r == MD_TX) begin
                            full_nxt = 1'b0;
                            ack_nxt = sda_s2;
                        end else if (mode_r == MD_RX) begin
                            full_nxt = 1'b1;
                            ctrl_clr = REQ_W'(8);
                        end else begin
                            ctrl_clr = REQ_W'(16);
                        end
                    end else begin
                        state_nxt  = ST_BIT_L;
                        sda_oe_nxt = mode_r == MD_TX && cnt_inc < NBITS_RX
                                     && !shift_nxt[BYTE_W-1];
                    end
                end
            end
        endcase
        if (coll) begin
            state_nxt  = ST_IDLE;
            scl_oe_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
            full_nxt   = 1'b0;
            ctrl_clr   = '1;
            flag_set[FL_BCL] = 1'b1;
        end
        if (watch_r && stop_bus) flag_set[FL_SPIF] = 1'b1;
        flag_set[FL_WR_COLL] = wr_coll;
    end

    // Request bits: a software write replaces the field, else hardware clears
    assign ctrl_nxt = ctrl_wr ? i2cm_ctrl_t'(pwdata[CTRL_W-1:0])
                              : ctrl_r & ~i2cm_ctrl_t'({1'b0, ctrl_clr});
    // Set wins over a same-cycle write-one-to-clear
    assign flag_nxt = (flag_r & ~((wr && sel_stat) ? pwdata[FLAG_W-1:0] : '0)) | flag_set;

    // ==========================================================
    // Baud rate generator
    wire baud_load = idle || (scl_rise && !scl_oe_r);
    wire baud_hold = !scl_oe_r && !scl_s2;

    i2cm_baud_gen #(.W(BAUD_W)) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (baud_load),
        .hold    (baud_hold),
        .reload  (baud_r),
        .tick    (tick)
    );

    // ==========================================================
    // State and registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            mode_r  <= MD_TX;
            shift_r <= '0;
            cnt_r   <= '0;
            full_r  <= 1'b0;
            ack_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r  <= mode_nxt;
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            full_r  <= full_nxt;
            ack_r   <= ack_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            flag_r <= FLAG_RST;
            en_r   <= 1'b0;
            baud_r <= BAUD_RST;
            mask_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            if (wr && sel_cfg)  en_r   <= pwdata[CFG_EN];
            if (wr && sel_baud) baud_r <= pwdata[BAUD_W-1:0];
            if (wr && sel_mask) mask_r <= pwdata[FLAG_W-1:0];
        end
    end

    // Bus state for software deciding when it may take the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdet_r  <= 1'b0;
            pdet_r  <= 1'b0;
            watch_r <= 1'b0;
        end else begin
            sdet_r  <= start_bus || (sdet_r && !stop_bus);
            pdet_r  <= stop_bus || (pdet_r && !start_bus);
            watch_r <= coll || (watch_r && !stop_bus);
        end
    end

    // ==========================================================
    // Outputs from flip-flops, except the SCL and SDA drive values, which are tied low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe_r  <= 1'b0;
            sda_oe_r  <= 1'b0;
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            scl_oe_r  <= scl_oe_nxt;
            sda_oe_r  <= sda_oe_nxt;
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) prdata_r <= rd_mux;
            irq_r     <= |(flag_nxt & mask_r);
        end
    end

    // Open-drain: the drive value is always low, only the enable moves
    assign scl_o   = 1'b0;
    assign sda_o   = 1'b0;
    assign scl_oe  = scl_oe_r;
    assign sda_oe  = sda_oe_r;
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_order_a: assert property (state_r == ST_STA_B |-> sda_oe_r && !scl_oe_r)
        else $error("start order wrong");
    stop_release_a: assert property (state_r == ST_STP_C && tick && sda_s2 |=>
        !scl_oe_r && !sda_oe_r && idle) else $error("stop not released");
    tx_bit_a: assert property (state_r == ST_BIT_L && mode_r == MD_TX && cnt_r < NBITS_RX
        |-> sda_oe_r == !shift_r[BYTE_W-1]) else $error("tx bit wrong");
    rx_release_a: assert property (mode_r == MD_RX && state_r == ST_BIT_H |-> !sda_oe_r)
        else $error("rx drives sda");
    busy_write_a: assert property (buf_wr && busy && !tick |=>
        flag_r[FL_WR_COLL] && $stable(shift_r))
        else $error("busy write not discarded");
    tx_coll_a: assert property (coll && mode_r == MD_TX && state_r == ST_BIT_H |=>
        !full_r && !scl_oe_r && !sda_oe_r) else $error("tx collision not released");
    coll_clear_a: assert property (coll && !ctrl_wr |=> ctrl_r[REQ_W-1:0] == '0)
        else $error("requests not cleared");
    stop_watch_a: assert property (watch_r && stop_bus |=> flag_r[FL_SPIF])
        else $error("stop after collision missed");
    first_bit_a: assert property (buf_ok && !(|ctrl_r[REQ_W-1:0]) |=>
        cnt_r == '0 && state_r == ST_BIT_L) else $error("not first bit");
    start_coll_a: assert property (state_r == ST_STA_A && (!scl_s2 || !sda_s2) |=>
        idle && flag_r[FL_BCL] && !scl_oe_r) else $error("start collision");
    coll_idle_a: assert property (coll |=> ##1 idle && !sda_oe_r)
        else $error("collision not idle");

    start_done_c: cover property (state_r == ST_STA_B && tick);
    byte_done_c:  cover property (mode_r == MD_TX && state_r == ST_BIT_H && tick
                                  && cnt_inc == NBITS_TX);
    coll_c:       cover property (coll);
    stop_seen_c:  cover property (watch_r && stop_bus);

endmodule : i2cm_master

// file: verif/i2cm_slave_model.sv
// I2C target model: acks its address and written bytes, returns one byte.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/1ps
module i2cm_slave_model (
    input  wire logic       pclk,     // Sample clock
    input  wire logic       scl,      // SCL line
    input  wire logic       sda,      // SDA line
    input  wire logic       stretch,  // Hold SCL low after each fall
    input  wire logic [7:0] rbyte,    // Byte returned on reads
    output logic            sda_low,  // Pull SDA low
    output logic            scl_low   // Pull SCL low
);
    logic       ps, pd, first, rd;
    logic [3:0] cnt;
    logic [4:0] hold;
    initial {first, rd, cnt, hold, sda_low} = '0;
    // Lines idle high, so no false rise is counted at time zero
    initial {ps, pd} = 2'b11;
    assign scl_low = (hold != 5'h00);
    // Data changes only after SCL falls, so a start is never faked
    always @(posedge pclk) begin
        ps <= scl;
        pd <= sda;
        if (scl && ps && pd && !sda) begin
            cnt   <= 4'h0;
            first <= 1'b1;
            rd    <= 1'b0;
        end else if (scl && !ps) begin
            if (first && cnt == 4'h7) rd <= sda;
            if (cnt == 4'h8 && sda) rd <= 1'b0;
            if (cnt == 4'h8) first <= 1'b0;
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        end else if (!scl && ps) begin
            sda_low <= (cnt == 4'h8) ? (first || !rd) : (rd && !first && !rbyte[3'h7 - cnt[2:0]]);
            hold    <= stretch ? 5'h14 : 5'h00;
        end else if (hold != 5'h00) begin
            hold <= hold - 5'h1;
        end
    end
endmodule : i2cm_slave_model

// file: verif/test_i2c_master_arbitration.sv
// Bench for the I2C master engine: APB master, wired-and bus, target model.
// Assumes a target that answers any address; APB wait states are polled.
`timescale 1ns/1ps
module test_i2c_master_arbitration import i2cm_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic        e;
    } i2cm_row_t;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic              scl_o, scl_oe, sda_o, sda_oe, s_sda, s_scl, stretch, tb_sda;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic [8:0]        sh;
    int                failures, cmp_count, hc, mn;
    wire               scl = !(scl_oe || s_scl);
    wire               sda = !(sda_oe || s_sda || tb_sda);
    i2cm_row_t rows [6] = '{'{OFS_CFG, 32'h0, 1'b0}, '{OFS_BAUD, 32'h13, 1'b0},
        '{OFS_CTRL, 32'h0, 1'b0}, '{OFS_STAT, 32'h0, 1'b0}, '{OFS_MASK, 32'h0, 1'b0},
        '{8'h18, 32'h0, 1'b1}};
    always #4 pclk = ~pclk;
    i2cm_master DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .irq, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
    i2cm_slave_model slave (.pclk, .scl, .sda, .stretch, .rbyte(8'h5a), .sda_low(s_sda),
        .scl_low(s_scl));
    always @(posedge scl) sh <= {sh[7:0], sda};
    // Shortest SCL high time, stretched or not
    always @(posedge pclk) begin
        if (scl) hc <= hc + 1;
        else begin
            if (hc != 0 && hc < mn) mn <= hc;
            hc <= 0;
        end
    end
    // ==========================================================
    // Tasks
    task automatic stop_test(input int extra);
        failures += extra;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Returns at the rising edge that samples the level high; data taken there
    task automatic wait_hi(input logic use_irq, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((use_irq ? irq : pready) !== 1'b1 && n < lim);
        if ((use_irq ? irq : pready) !== 1'b1) stop_test(1);
        r = prdata;
        e = pslverr;
    endtask : wait_hi
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(1'b0, 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r & m, x);
    endtask : rdc
    task automatic go(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, OFS_STAT, 32'h7);
        apb(1'b1, a, d);
        wait_hi(1'b1, 4000);
    endtask : go
    // ==========================================================
    // Sequence
    initial begin
        {presetn, psel, penable, pwrite, stretch, tb_sda, paddr, pwdata, sh} = '0;
        {failures, cmp_count, hc, mn} = {32'd0, 32'd0, 32'd0, 32'd99};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            rdc(rows[i].a, 32'hffffffff, rows[i].d);
            chk(e, rows[i].e);
        end
        apb(1'b1, OFS_CFG, 32'h1);
        apb(1'b1, OFS_BAUD, 32'h2);
        // Write collision kept off irq, so the waits see the sequence end
        apb(1'b1, OFS_MASK, 32'h3);
        go(OFS_CTRL, 32'h1);
        apb(1'b1, OFS_STAT, 32'h7);
        apb(1'b1, OFS_BUF, 32'ha4);
        apb(1'b1, OFS_BUF, 32'h33);
        wait_hi(1'b1, 4000);
        rdc(OFS_STAT, 32'h17, 32'h5);
        chk(sh, {8'ha4, 1'b0});
        stretch <= 1'b1;
        go(OFS_BUF, 32'h3c);
        stretch <= 1'b0;
        chk(sh, {8'h3c, 1'b0});
        chk(32'(mn >= 3), 32'h1);
        go(OFS_CTRL, 32'h2);
        go(OFS_BUF, 32'ha5);
        rdc(OFS_STAT, 32'h10, 32'h0);
        go(OFS_CTRL, 32'h8);
        rdc(OFS_BUF, 32'hff, 32'h5a);
        go(OFS_CTRL, 32'h30);
        chk(sh[0], 1'b1);
        go(OFS_CTRL, 32'h4);
        chk({scl, sda}, 2'b11);
        tb_sda <= 1'b1;
        go(OFS_CTRL, 32'h1);
        rdc(OFS_STAT, 32'h2, 32'h2);
        rdc(OFS_CTRL, 32'h3f, 32'h0);
        chk({scl_oe, sda_oe}, 2'b00);
        apb(1'b1, OFS_STAT, 32'h7);
        tb_sda <= 1'b0;
        wait_hi(1'b1, 4000);
        rdc(OFS_STAT, 32'h7, 32'h1);
        apb(1'b1, OFS_MASK, 32'h6);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, OFS_MASK, 32'h7);
        @(posedge pclk);
        chk(irq, 1'b1);
        stop_test(0);
    end
endmodule : test_i2c_master_arbitration
